// ### src/twc_apb_regs.sv
`timescale 1ns/1ps
`default_nettype none
module twc_apb_regs (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // control out
    output logic sm_act_o,
    output logic cnt2_prot_o,
    output logic [1:0] card_state_o,
    output logic [7:0] prot_start_o,
    output logic [63:0] lock_o,
    output logic [5:0] page_sel_o,
    output logic [2:0] cnt_we_o,
    output logic [23:0] cnt_wdata_o,
    // status in
    input wire logic [15:0] cmd_ctr_i,
    input wire logic [3:0] last_code_i,
    input wire logic busy_i,
    input wire logic [31:0] page_data_i,
    input wire logic [71:0] cnt_i
);
    logic [3:0] ctrl_reg;
    logic [7:0] prot_reg;
    logic [31:0] lock_lo_reg;
    logic [31:0] lock_hi_reg;
    logic [5:0] sel_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rd_next;
    logic hit;
    logic wr;

    assign wr = psel_i && penable_i && pwrite_i;

    always_comb begin
        hit = 1'b1;
        rd_next = 32'h0000_0000;
        case (paddr_i)
            twc_pkg::REG_CTRL: rd_next = {28'h000_0000, ctrl_reg};
            twc_pkg::REG_PROT: rd_next = {24'h00_0000, prot_reg};
            twc_pkg::REG_LOCK_LO: rd_next = lock_lo_reg;
            twc_pkg::REG_LOCK_HI: rd_next = lock_hi_reg;
            twc_pkg::REG_STATUS: begin
                rd_next[15:0] = cmd_ctr_i;
                rd_next[twc_pkg::STAT_CODE_LSB +: 4] = last_code_i;
                rd_next[twc_pkg::STAT_BUSY_BIT] = busy_i;
            end
            twc_pkg::REG_PAGE_SEL: rd_next = {26'h000_0000, sel_reg};
            twc_pkg::REG_PAGE_DATA: rd_next = page_data_i;
            twc_pkg::REG_CNT0: rd_next = {8'h00, cnt_i[23:0]};
            twc_pkg::REG_CNT1: rd_next = {8'h00, cnt_i[47:24]};
            twc_pkg::REG_CNT2: rd_next = {8'h00, cnt_i[71:48]};
            default: hit = 1'b0;
        endcase
    end

    // read data captured in the setup cycle, so the access phase needs no wait
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel_i && !penable_i) begin
            prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_next;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= twc_pkg::CTRL_RST;
            prot_reg <= twc_pkg::PROT_RST;
            lock_lo_reg <= twc_pkg::LOCK_RST;
            lock_hi_reg <= twc_pkg::LOCK_RST;
            sel_reg <= 6'h00;
        end else if (wr) begin
            case (paddr_i)
                twc_pkg::REG_CTRL: ctrl_reg <= pwdata_i[3:0];
                twc_pkg::REG_PROT: prot_reg <= pwdata_i[7:0];
                twc_pkg::REG_LOCK_LO: lock_lo_reg <= pwdata_i;
                twc_pkg::REG_LOCK_HI: lock_hi_reg <= pwdata_i;
                twc_pkg::REG_PAGE_SEL: sel_reg <= pwdata_i[5:0];
                default: ;
            endcase
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;
    assign sm_act_o = ctrl_reg[twc_pkg::CTRL_SM_BIT];
    assign cnt2_prot_o = ctrl_reg[twc_pkg::CTRL_CNT2_BIT];
    assign card_state_o = ctrl_reg[twc_pkg::CTRL_STATE_LSB +: 2];
    assign prot_start_o = prot_reg;
    assign lock_o = {lock_hi_reg, lock_lo_reg};
    assign page_sel_o = sel_reg;
    assign cnt_we_o[0] = wr && paddr_i == twc_pkg::REG_CNT0;
    assign cnt_we_o[1] = wr && paddr_i == twc_pkg::REG_CNT1;
    assign cnt_we_o[2] = wr && paddr_i == twc_pkg::REG_CNT2;
    assign cnt_wdata_o = pwdata_i[23:0];
endmodule : twc_apb_regs
`default_nettype wire

// ### src/twc_pkg.sv
package twc_pkg;
    // command opcodes and page limits
    localparam logic [7:0] OP_WRITE = 8'hA2;
    localparam logic [7:0] OP_CNT_READ = 8'h39;
    localparam logic [7:0] PAGE_FIRST = 8'h02;
    localparam logic [7:0] PAGE_LAST = 8'h3B;
    localparam logic [7:0] PAGE_LOCK01 = 8'h02;
    localparam logic [7:0] PAGE_OTP = 8'h03;
    localparam logic [7:0] PAGE_LOCK234 = 8'h28;
    localparam logic [7:0] CNT_LAST = 8'h02;
    // answer codes
    localparam logic [3:0] CODE_ACK = 4'hA;
    localparam logic [3:0] CODE_NAK_ARG = 4'h0;
    localparam logic [3:0] CODE_NAK_CRC = 4'h1;
    // frame lengths in bytes, crc stripped
    localparam logic [4:0] LEN_WRITE = 5'h06;
    localparam logic [4:0] LEN_CNT_READ = 5'h02;
    localparam logic [4:0] LEN_CMAC = 5'h08;
    localparam logic [3:0] RESP_CNT = 4'h3;
    localparam logic [3:0] RESP_MAC = 4'h8;
    localparam logic [3:0] RESP_NIB = 4'h1;
    // card states
    localparam logic [1:0] CARD_ACTIVE = 2'h0;
    localparam logic [1:0] CARD_TRACEABLE = 2'h1;
    localparam logic [1:0] CARD_AUTH = 2'h2;
    // register byte offsets
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_PROT = 12'h004;
    localparam logic [11:0] REG_LOCK_LO = 12'h008;
    localparam logic [11:0] REG_LOCK_HI = 12'h00C;
    localparam logic [11:0] REG_STATUS = 12'h010;
    localparam logic [11:0] REG_PAGE_SEL = 12'h014;
    localparam logic [11:0] REG_PAGE_DATA = 12'h018;
    localparam logic [11:0] REG_CNT0 = 12'h01C;
    localparam logic [11:0] REG_CNT1 = 12'h020;
    localparam logic [11:0] REG_CNT2 = 12'h024;
    // fields and reset values
    localparam int CTRL_SM_BIT = 0;
    localparam int CTRL_CNT2_BIT = 1;
    localparam int CTRL_STATE_LSB = 2;
    localparam int STAT_CODE_LSB = 16;
    localparam int STAT_BUSY_BIT = 20;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [7:0] PROT_RST = 8'hFF;
    localparam logic [31:0] LOCK_RST = 32'h0000_0000;
    // timing: frame delay n=9 on the carrier, reader timeout 5 ms
    localparam longint FDT_N = 9;
    localparam longint FC_HZ = 13_560_000;
    localparam longint CLK_HZ = 125_000_000;
    localparam longint FDT_CARRIER = FDT_N * 128 + 84;
    localparam longint FDT_CYC = (FDT_CARRIER * CLK_HZ + FC_HZ - 1) / FC_HZ;
    localparam longint TIMEOUT_US = 5;
    localparam longint TIMEOUT_CYC = TIMEOUT_US * 1000 * CLK_HZ / 1_000_000;
    typedef enum logic [1:0] {S_IDLE, S_EXEC, S_WAIT, S_SEND} twc_fsm_t;
    function automatic logic twc_tear_page(input logic [7:0] a);
        return a == PAGE_LOCK01 || a == PAGE_OTP || a == PAGE_LOCK234;
    endfunction : twc_tear_page
endpackage : twc_pkg

// ### src/twc_top.sv
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - page write: opcode, address, four bytes, stored
// - secure messaging adds eight-byte cmac to both commands and to non-nak answers
// - write answer: ack/nak, or mac plus crc
// - answer no sooner than n=9 delay
// - writable pages 02h to 3Bh, else nak
// - locked pages never change on write
// - unauthenticated write at protected start gets nak
// - traceable secure write needs valid cmac
// - authenticated state ignores protected page start
// - lock and otp pages written tear-safe
// - counter read returns three bytes plus crc
// - protected counter two only when authenticated
// - secure counter read needs valid cmac
module twc_top #(
    parameter int FDT_CYCLES = int'(twc_pkg::FDT_CYC),
    parameter int TIMEOUT_CYCLES = int'(twc_pkg::TIMEOUT_CYC)
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // received frame, crc already checked and stripped
    input wire logic RX_VALID_I,
    input wire logic [7:0] RX_DATA_I,
    input wire logic RX_END_I,
    input wire logic RX_CRC_OK_I,
    // cmac engine
    input wire logic CMAC_OK_I,
    input wire logic [63:0] RESP_MAC_I,
    output logic [15:0] CMD_COUNTER_O,
    // answer stream, framer appends crc unless nibble
    output logic TX_VALID_O,
    output logic [7:0] TX_DATA_O,
    output logic TX_NIBBLE_O,
    output logic TX_LAST_O,
    input wire logic TX_READY_I
);
    twc_pkg::twc_fsm_t st_reg;
    logic [7:0] buf_reg [0:15];
    logic [4:0] len_reg;
    logic crc_ok_reg;
    logic mac_ok_reg;
    logic [31:0] page_mem [0:63];
    logic [23:0] cnt_reg [0:2];
    logic stage_valid_reg;
    logic [7:0] stage_addr_reg;
    logic [31:0] stage_data_reg;
    logic resp_nib_reg;
    logic resp_mac_wr_reg;
    logic [3:0] resp_code_reg;
    logic [3:0] resp_len_reg;
    logic [23:0] resp_cnt_reg;
    logic [19:0] wait_reg;
    logic [15:0] cmd_ctr_reg;
    logic [3:0] last_code_reg;
    logic [19:0] since_reg;
    // settings from software
    logic sm_act;
    logic cnt2_prot;
    logic [1:0] card_state;
    logic [7:0] prot_start;
    logic [63:0] lock;
    logic [5:0] page_sel;
    logic [2:0] cnt_we;
    logic [23:0] cnt_wdata;
    // decode
    logic exec;
    logic [7:0] op;
    logic [7:0] arg;
    logic [4:0] mac_len;
    logic mac_fail;
    logic wr_range;
    logic wr_prot;
    logic wr_lock;
    logic cnt_deny;
    logic d_send;
    logic d_nib;
    logic d_we;
    logic d_cnt_ok;
    logic d_mac_wr;
    logic [3:0] d_code;
    logic [3:0] d_len;
    // serializer
    logic ser_load;
    logic ser_busy;
    logic [87:0] ser_data;

    assign exec = st_reg == twc_pkg::S_EXEC;
    assign op = buf_reg[0];
    assign arg = buf_reg[1];
    assign mac_len = sm_act ? twc_pkg::LEN_CMAC : 5'h00;
    assign mac_fail = sm_act && !mac_ok_reg;
    assign wr_range = arg >= twc_pkg::PAGE_FIRST && arg <= twc_pkg::PAGE_LAST;
    assign wr_prot = card_state != twc_pkg::CARD_AUTH && arg >= prot_start;
    assign wr_lock = lock[arg[5:0]];
    assign cnt_deny = arg > twc_pkg::CNT_LAST ||
        (arg == twc_pkg::CNT_LAST && cnt2_prot && card_state != twc_pkg::CARD_AUTH);

    // unknown opcodes with a good crc get no answer; a known opcode with a bad length gets nak
    always_comb begin
        d_send = 1'b1;
        d_nib = 1'b1;
        d_we = 1'b0;
        d_cnt_ok = 1'b0;
        d_mac_wr = 1'b0;
        d_code = twc_pkg::CODE_NAK_ARG;
        d_len = twc_pkg::RESP_NIB;
        if (!crc_ok_reg) begin
            d_code = twc_pkg::CODE_NAK_CRC;
        end else if (op == twc_pkg::OP_WRITE) begin
            if (len_reg == 5'(twc_pkg::LEN_WRITE + mac_len) && wr_range && !wr_lock && !wr_prot
                && !mac_fail) begin
                d_we = 1'b1;
                if (sm_act) begin
                    d_nib = 1'b0;
                    d_mac_wr = 1'b1;
                    d_len = twc_pkg::RESP_MAC;
                end else begin
                    d_code = twc_pkg::CODE_ACK;
                end
            end
        end else if (op == twc_pkg::OP_CNT_READ) begin
            if (len_reg == 5'(twc_pkg::LEN_CNT_READ + mac_len) && !cnt_deny && !mac_fail) begin
                d_cnt_ok = 1'b1;
                d_nib = 1'b0;
                d_len = sm_act ? 4'(twc_pkg::RESP_CNT + twc_pkg::RESP_MAC) : twc_pkg::RESP_CNT;
            end
        end else begin
            d_send = 1'b0;
        end
    end

    // frame collection; the length stops at sixteen and later bytes are dropped, so it mismatches
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            len_reg <= 5'h00;
            crc_ok_reg <= 1'b0;
            mac_ok_reg <= 1'b0;
        end else if (st_reg == twc_pkg::S_IDLE) begin
            if (RX_VALID_I && len_reg != 5'h10) begin
                len_reg <= len_reg + 5'h01;
            end
            if (RX_END_I) begin
                crc_ok_reg <= RX_CRC_OK_I;
                mac_ok_reg <= CMAC_OK_I;
            end
        end else if (exec) begin
            len_reg <= 5'h00;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (st_reg == twc_pkg::S_IDLE && RX_VALID_I && len_reg < 5'h10) begin
            buf_reg[len_reg[3:0]] <= RX_DATA_I;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            st_reg <= twc_pkg::S_IDLE;
            wait_reg <= 20'h0_0000;
        end else begin
            case (st_reg)
                twc_pkg::S_IDLE: if (RX_END_I) st_reg <= twc_pkg::S_EXEC;
                twc_pkg::S_EXEC: begin
                    wait_reg <= 20'h0_0000;
                    st_reg <= d_send ? twc_pkg::S_WAIT : twc_pkg::S_IDLE;
                end
                twc_pkg::S_WAIT: begin
                    wait_reg <= wait_reg + 20'h0_0001;
                    if (ser_load) st_reg <= twc_pkg::S_SEND;
                end
                twc_pkg::S_SEND: if (!ser_busy) st_reg <= twc_pkg::S_IDLE;
                default: st_reg <= twc_pkg::S_IDLE;
            endcase
        end
    end

    // the answer is held back for the full frame delay after the frame ends
    assign ser_load = st_reg == twc_pkg::S_WAIT && wait_reg == 20'(FDT_CYCLES - 1);

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            resp_nib_reg <= 1'b1;
            resp_mac_wr_reg <= 1'b0;
            resp_code_reg <= twc_pkg::CODE_NAK_ARG;
            resp_len_reg <= twc_pkg::RESP_NIB;
            resp_cnt_reg <= 24'h00_0000;
            last_code_reg <= twc_pkg::CODE_NAK_ARG;
        end else if (exec) begin
            resp_nib_reg <= d_nib;
            resp_mac_wr_reg <= d_mac_wr;
            resp_code_reg <= d_code;
            resp_len_reg <= d_len;
            resp_cnt_reg <= d_cnt_ok ? cnt_reg[arg[1:0]] : 24'h00_0000;
            if (d_send) last_code_reg <= d_code;
        end
    end

    // command_counter advances on every accepted command
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cmd_ctr_reg <= 16'h0000;
        end else if (exec && (d_we || d_cnt_ok)) begin
            cmd_ctr_reg <= cmd_ctr_reg + 16'h0001;
        end
    end

    // all checks finish before staging, so a page changes in one edge or not at all
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            stage_valid_reg <= 1'b0;
            stage_addr_reg <= 8'h00;
            stage_data_reg <= 32'h0000_0000;
        end else begin
            stage_valid_reg <= exec && d_we;
            if (exec) begin
                stage_addr_reg <= arg;
                stage_data_reg <= {buf_reg[5], buf_reg[4], buf_reg[3], buf_reg[2]};
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (stage_valid_reg) begin
            page_mem[stage_addr_reg[5:0]] <= stage_data_reg;
        end
    end

    // counters are only preloaded by software here; incrementing lives elsewhere
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            for (int i = 0; i < 3; i++) cnt_reg[i] <= 24'h00_0000;
        end else begin
            for (int i = 0; i < 3; i++) if (cnt_we[i]) cnt_reg[i] <= cnt_wdata;
        end
    end

    // mac is taken at load time, long after the frame, so the engine has time
    always_comb begin
        if (resp_nib_reg) ser_data = {84'h0, resp_code_reg};
        else if (resp_mac_wr_reg) ser_data = {24'h00_0000, RESP_MAC_I};
        else ser_data = {RESP_MAC_I, resp_cnt_reg};
    end

    twc_tx_ser u_ser (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RESET_N_I),
        .load_i(ser_load),
        .data_i(ser_data),
        .len_i(resp_len_reg),
        .nib_i(resp_nib_reg),
        .ready_i(TX_READY_I),
        .valid_o(TX_VALID_O),
        .data_o(TX_DATA_O),
        .nib_o(TX_NIBBLE_O),
        .last_o(TX_LAST_O),
        .busy_o(ser_busy)
    );

    twc_apb_regs u_regs (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RESET_N_I),
        .psel_i(PSEL_I),
        .penable_i(PENABLE_I),
        .pwrite_i(PWRITE_I),
        .paddr_i(PADDR_I),
        .pwdata_i(PWDATA_I),
        .prdata_o(PRDATA_O),
        .pready_o(PREADY_O),
        .pslverr_o(PSLVERR_O),
        .sm_act_o(sm_act),
        .cnt2_prot_o(cnt2_prot),
        .card_state_o(card_state),
        .prot_start_o(prot_start),
        .lock_o(lock),
        .page_sel_o(page_sel),
        .cnt_we_o(cnt_we),
        .cnt_wdata_o(cnt_wdata),
        .cmd_ctr_i(cmd_ctr_reg),
        .last_code_i(last_code_reg),
        .busy_i(st_reg != twc_pkg::S_IDLE),
        .page_data_i(page_mem[page_sel]),
        .cnt_i({cnt_reg[2], cnt_reg[1], cnt_reg[0]})
    );

    assign CMD_COUNTER_O = cmd_ctr_reg;

    // cycles since the last frame end, for the delay checks
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) since_reg <= 20'h0_0000;
        else if (st_reg == twc_pkg::S_IDLE && RX_END_I) since_reg <= 20'h0_0000;
        else if (since_reg != 20'hF_FFFF) since_reg <= since_reg + 20'h0_0001;
    end

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RESET_N_I);

    sequence wr_exec_s;
        exec && crc_ok_reg && op == twc_pkg::OP_WRITE;
    endsequence

    sequence deny2_s;
        exec && crc_ok_reg && op == twc_pkg::OP_CNT_READ && arg == twc_pkg::CNT_LAST && cnt2_prot
            && card_state != twc_pkg::CARD_AUTH;
    endsequence

    wr_range_a: assert property (stage_valid_reg |-> stage_addr_reg >= twc_pkg::PAGE_FIRST
        && stage_addr_reg <= twc_pkg::PAGE_LAST)
        else $error("write staged outside the writable pages");
    lock_keep_a: assert property (wr_exec_s ##0 wr_lock |=> !stage_valid_reg ##1 !stage_valid_reg)
        else $error("locked page was written");
    prot_nak_a: assert property (wr_exec_s ##0 wr_prot |=> !stage_valid_reg && resp_nib_reg
        && resp_code_reg == twc_pkg::CODE_NAK_ARG)
        else $error("protected page write not refused with nak");
    auth_write_a: assert property (wr_exec_s ##0 card_state == twc_pkg::CARD_AUTH && wr_range
        && !wr_lock && !mac_fail && len_reg == 5'(twc_pkg::LEN_WRITE + mac_len) |=> stage_valid_reg)
        else $error("authenticated write did not proceed");
    mac_need_a: assert property (exec && crc_ok_reg && mac_fail |=> !stage_valid_reg
        && resp_nib_reg)
        else $error("command without valid cmac was served");
    tear_atom_a: assert property (stage_valid_reg |-> $past(exec))
        else $error("page update not from a completed check");
    fdt_min_a: assert property (ser_load |-> since_reg >= 20'(FDT_CYCLES)
        && since_reg < 20'(TIMEOUT_CYCLES))
        else $error("answer outside the frame delay window");
    nak_form_a: assert property (ser_load && resp_nib_reg |=> TX_VALID_O && TX_NIBBLE_O
        && TX_LAST_O && TX_DATA_O[3:0] == $past(resp_code_reg))
        else $error("ack or nak not sent as one nibble");
    cnt_len_a: assert property (exec && d_cnt_ok |=> resp_len_reg == (sm_act
        ? 4'(twc_pkg::RESP_CNT + twc_pkg::RESP_MAC) : twc_pkg::RESP_CNT))
        else $error("counter answer has wrong length");
    cnt2_deny_a: assert property (deny2_s |=> resp_nib_reg && resp_code_reg == twc_pkg::CODE_NAK_ARG)
        else $error("protected counter read not refused");
endmodule : twc_top
`default_nettype wire

// ### src/twc_tx_ser.sv
`timescale 1ns/1ps
`default_nettype none
module twc_tx_ser (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // load side
    input wire logic load_i,
    input wire logic [87:0] data_i,
    input wire logic [3:0] len_i,
    input wire logic nib_i,
    // byte stream
    input wire logic ready_i,
    output logic valid_o,
    output logic [7:0] data_o,
    output logic nib_o,
    output logic last_o,
    output logic busy_o
);
    logic [87:0] sh_reg;
    logic [3:0] cnt_reg;
    logic nib_reg;

    // bytes leave low byte first
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh_reg <= '0;
            cnt_reg <= 4'h0;
            nib_reg <= 1'b0;
        end else if (load_i) begin
            sh_reg <= data_i;
            cnt_reg <= len_i;
            nib_reg <= nib_i;
        end else if (valid_o && ready_i) begin
            sh_reg <= {8'h00, sh_reg[87:8]};
            cnt_reg <= cnt_reg - 4'h1;
        end
    end

    assign valid_o = cnt_reg != 4'h0;
    assign data_o = sh_reg[7:0];
    assign nib_o = nib_reg;
    assign last_o = cnt_reg == 4'h1;
    assign busy_o = valid_o;
endmodule : twc_tx_ser
`default_nettype wire

// ### tb/tag_write_and_counter_read_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tag_write_and_counter_read_tb;
    localparam int FDT = 20;
    localparam logic [7:0] ACK = {4'h0, twc_pkg::CODE_ACK};
    localparam logic [7:0] NAK = {4'h0, twc_pkg::CODE_NAK_ARG};
    localparam logic [7:0] W = twc_pkg::OP_WRITE;
    localparam logic [7:0] R = twc_pkg::OP_CNT_READ;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, err, rx_valid, rx_end, rx_crc_ok, cmac_ok, tx_valid, tx_nib, tx_last, tx_ready;
    logic [7:0] rx_data, tx_data;
    logic [15:0] cmd_ctr;
    int error_cnt = 0;
    int check_count = 0;
    initial begin
        forever #4 clk = ~clk;
    end
    twc_top #(.FDT_CYCLES(FDT), .TIMEOUT_CYCLES(1000)) i_dut (
        .CLK_SYS_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .RX_VALID_I(rx_valid), .RX_DATA_I(rx_data), .RX_END_I(rx_end), .RX_CRC_OK_I(rx_crc_ok),
        .CMAC_OK_I(cmac_ok), .RESP_MAC_I(64'h8877_6655_4433_2211), .CMD_COUNTER_O(cmd_ctr),
        .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data), .TX_NIBBLE_O(tx_nib), .TX_LAST_O(tx_last),
        .TX_READY_I(tx_ready));
    twc_reader i_rd (.clk_i(clk), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_end_o(rx_end),
        .rx_crc_ok_o(rx_crc_ok), .cmac_ok_o(cmac_ok), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .tx_nibble_i(tx_nib), .tx_last_i(tx_last), .tx_ready_o(tx_ready));
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // no fixed wait count; the watchdog ends a hung access
        while (pready !== 1'b1) @(posedge clk);
        {q, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic page(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b1, twc_pkg::REG_PAGE_SEL, {24'h0, a});
        apb(1'b0, twc_pkg::REG_PAGE_DATA, 32'h0);
        chk(q, exp);
    endtask : page
    task automatic cmd(input logic [127:0] f, input int n, input logic mac, input int en, input logic [7:0] b0);
        i_rd.xfer(f, n, mac);
        chk(i_rd.ans_n, en);
        chk(i_rd.ans[0], b0);
        chk(i_rd.ans_nib, en == 1);
        chk(i_rd.vis_at, FDT + 2);
    endtask : cmd
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, twc_pkg::REG_PROT, 32'h0);
        chk(q, {24'h0, twc_pkg::PROT_RST});
        cmd({32'hCAFE_0001, 8'h05, W}, 6, 1'b0, 1, ACK);
        page(8'h05, 32'hCAFE_0001);
        chk(cmd_ctr, 32'h1);
        cmd({32'h0, 8'h3B, W}, 6, 1'b0, 1, ACK);
        cmd({32'h0, 8'h3C, W}, 6, 1'b0, 1, NAK);
        cmd({32'h0, 8'h01, W}, 6, 1'b0, 1, NAK);
        apb(1'b1, twc_pkg::REG_LOCK_LO, 32'h0000_0020);
        cmd({32'h1111_2222, 8'h05, W}, 6, 1'b0, 1, NAK);
        page(8'h05, 32'hCAFE_0001);
        apb(1'b1, twc_pkg::REG_PROT, 32'h0000_0010);
        cmd({32'h0, 8'h10, W}, 6, 1'b0, 1, NAK);
        cmd({32'h0, 8'h0F, W}, 6, 1'b0, 1, ACK);
        apb(1'b1, twc_pkg::REG_CTRL, 32'h0000_0008);
        cmd({32'h5A5A_0010, 8'h10, W}, 6, 1'b0, 1, ACK);
        page(8'h10, 32'h5A5A_0010);
        cmd({32'h0000_00F0, 8'h02, W}, 6, 1'b0, 1, ACK);
        page(8'h02, 32'h0000_00F0);
        apb(1'b1, twc_pkg::REG_CNT0, 32'h0012_3456);
        apb(1'b1, twc_pkg::REG_CNT2, 32'h00AB_CDEF);
        apb(1'b1, twc_pkg::REG_CTRL, 32'h0000_0002);
        cmd({8'h00, R}, 2, 1'b0, 3, 8'h56);
        chk(i_rd.ans[2], 8'h12);
        cmd({8'h03, R}, 2, 1'b0, 1, NAK);
        cmd({8'h02, R}, 2, 1'b0, 1, NAK);
        apb(1'b1, twc_pkg::REG_CTRL, 32'h0000_000A);
        cmd({8'h02, R}, 2, 1'b0, 3, 8'hEF);
        apb(1'b1, twc_pkg::REG_CTRL, 32'h0000_0005);
        cmd({32'h0, 8'h06, W}, 14, 1'b0, 1, NAK);
        cmd({32'h0, 8'h06, W}, 14, 1'b1, 8, 8'h11);
        chk(i_rd.ans[7], 8'h88);
        cmd({8'h00, R}, 10, 1'b0, 1, NAK);
        cmd({8'h00, R}, 10, 1'b1, 11, 8'h56);
        chk(i_rd.ans[3], 8'h11);
        // a frame with a bad crc gets the crc nak code, not a counter value
        i_rd.crc_bad = 1'b1;
        cmd({8'h00, R}, 10, 1'b1, 1, {4'h0, twc_pkg::CODE_NAK_CRC});
        i_rd.crc_bad = 1'b0;
        apb(1'b0, 12'h040, 32'h0);
        chk({31'h0, err}, 32'h1);
        summarize();
    end
endmodule : tag_write_and_counter_read_tb
`default_nettype wire

// ### tb/twc_reader.sv
`timescale 1ns/1ps
`default_nettype none
module twc_reader (
    // clock
    input wire logic clk_i,
    // command bytes
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_end_o,
    output logic rx_crc_ok_o,
    output logic cmac_ok_o,
    // answer bytes
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_nibble_i,
    input wire logic tx_last_i,
    output logic tx_ready_o
);
    logic [7:0] ans[16];
    int ans_n, vis_at;
    logic ans_nib;
    logic crc_bad = 1'b0;
    initial begin
        {rx_valid_o, rx_data_o, rx_end_o, rx_crc_ok_o, cmac_ok_o, tx_ready_o} = 13'h0000;
    end
    // call right after an edge; the answer is taken with a stall on every other cycle
    task automatic xfer(input logic [127:0] f, input int n, input logic mac_ok);
        int w;
        logic done;
        {w, ans_n, vis_at} = 96'h0;
        done = 1'b0;
        for (int i = 0; i < n; i++) begin
            {rx_valid_o, rx_data_o} <= {1'b1, f[i*8 +: 8]};
            @(posedge clk_i);
        end
        // released data line shows the inverse, never the last byte
        {rx_valid_o, rx_data_o, rx_end_o, rx_crc_ok_o} <= {1'b0, ~f[n*8-8 +: 8], 1'b1, !crc_bad};
        cmac_ok_o <= mac_ok;
        @(posedge clk_i);
        rx_end_o <= 1'b0;
        while (!done && w < 1000) begin
            @(posedge clk_i);
            w++;
            if (tx_valid_i && vis_at == 0) vis_at = w;
            if (tx_valid_i && tx_ready_o) begin
                ans[ans_n[3:0]] = tx_data_i;
                ans_nib = tx_nibble_i;
                ans_n++;
                done = tx_last_i;
            end
            tx_ready_o <= w[0] && !done;
        end
        // the block is back in idle only one edge after the last byte is taken
        @(posedge clk_i);
    endtask : xfer
endmodule : twc_reader
`default_nettype wire
